/* File: pia_arbiter.sv */
// Purpose: prioritising interrupt and event transfer arbiter with registers
// Assumes: request pulses and cpu strobes are on aclk; AXI4-Lite slave
// Notes: the transfer engine and vector table sit outside this block
//
// Function
// - pending flag sets on source request, clears on service entry or transfer
// - transfer that takes count to zero leaves pending flag set
// - software write of pending flag acts exactly like hardware set/clear
// - 4-bit priority level ranks requests, larger value wins
// - same level ties broken by 2-bit group level, larger wins
// - service entry pushes old status word then loads winner's level
// - accept only if level strictly above cpu level; software may rewrite
// - up to 15 nested levels; level zero never arbitrates
// - levels 15 and 14 use transfer channel unless its count is zero
// - levels 13..1 always go to cpu interrupt, no count checked
// - level zero never serviced, but enabled request ends idle
// - channel number is level lsb and group level
// - simultaneous channel requests served highest channel first
// - transfer takes one cycle and leaves cpu level untouched
// - hardware trap raises cpu level to 15
// - software trap leaves cpu level unchanged
// - global enable gates transfers and interrupts; issued ones complete
// - with global enable set every individually enabled source of nonzero level competes
// - traps ignore the global enable
// - status word: level in 15..12, global enable in bit 11
// - one winner per instruction cycle end, served if above cpu level
// - request from a source whose enable bit is clear sets its pending flag but neither competes nor wakes idle
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module pia_arbiter
    import pia_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // peripheral sources and cpu core
    input wire logic [NSRC-1:0] src_req,
    input wire logic cycle_end,
    input wire logic hw_trap,
    input wire logic sw_trap,
    input wire logic psw_pop,
    input wire logic [15:0] psw_pop_data,
    // service outputs
    output pia_isr_t isr,
    output pia_xfer_t xfer,
    output pia_push_t push,
    output logic idle_wake
);
    pia_src_t src_q [NSRC];
    logic [7:0] cnt_q [NCHAN];
    logic [15:0] psw_q;
    logic [AW-1:0] awaddr_q, araddr_q;
    logic aw_held_q, w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    function automatic logic [31:0] merge(input logic [31:0] o,
            input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic src_hit(input logic [AW-1:0] a);
        return a[AW-1:6] == SRC_BASE[AW-1:6];
    endfunction : src_hit

    function automatic logic chan_hit(input logic [AW-1:0] a);
        return a[AW-1:5] == CHAN_BASE[AW-1:5];
    endfunction : chan_hit

    // status word fields
    wire [3:0] cpu_lvl = psw_q[PSW_LVL_LSB +: 4];
    wire global_irq_enable = psw_q[PSW_GLOBAL_EN_BIT];

    // write path: address and data taken in either order
    wire wr_go = aw_held_q && w_held_q && !bvalid;
    wire [3:0] wr_idx = awaddr_q[5:2];
    wire [2:0] wr_ch = awaddr_q[4:2];
    wire wr_src = wr_go && src_hit(awaddr_q);
    wire wr_chan = wr_go && chan_hit(awaddr_q);
    wire wr_psw = wr_go && (awaddr_q == PSW_ADDR);
    wire [31:0] src_old = {24'h0000_00, src_q[wr_idx]};
    wire [31:0] src_new = merge(src_old, wdata_q, wstrb_q);
    wire [31:0] cnt_new = merge({24'h0000_00, cnt_q[wr_ch]}, wdata_q,
        wstrb_q);
    wire [31:0] psw_new = merge({16'h0000, psw_q}, wdata_q, wstrb_q);
    assign awready = !aw_held_q;
    assign wready = !w_held_q;

    // arbitration over eligible sources
    logic [NSRC-1:0] elig;
    logic win_found;
    logic [3:0] win_idx;
    logic [5:0] win_key;
    always_comb begin
        win_found = 1'b0;
        win_idx = 4'h0;
        win_key = 6'h00;
        for (int i = 0; i < NSRC; i++) begin
            // level zero or disabled never competes
            elig[i] = src_q[i].pend && src_q[i].en && (src_q[i].lvl != 4'h0);
            // strict compare keeps the lowest index on a tie
            if (elig[i] && (!win_found ||
                    {src_q[i].lvl, src_q[i].grp} > win_key)) begin
                win_found = 1'b1;
                win_idx = 4'(i);
                win_key = {src_q[i].lvl, src_q[i].grp};
            end
        end
    end

    wire [3:0] win_lvl = win_key[5:2];
    wire [2:0] win_ch = {win_key[2], win_key[1:0]};
    wire trap_any = hw_trap || sw_trap;
    // served at cycle end, gated by global enable
    wire accept = cycle_end && win_found && global_irq_enable && !trap_any &&
        (win_lvl > cpu_lvl);
    // only 111x with nonzero count goes to a channel
    wire to_xfer = (win_lvl[3:1] == XFER_LVL) && (cnt_q[win_ch] != 8'h00);
    wire do_xfer = accept && to_xfer;
    wire do_isr = accept && !to_xfer;
    wire [7:0] cnt_dec = (cnt_q[win_ch] == CNT_CONT) ? CNT_CONT :
        cnt_q[win_ch] - 8'h01;
    wire xfer_last = cnt_dec == 8'h00;

    // any enabled pending source, level zero included, wakes idle cpu
    logic [NSRC-1:0] wake_vec;
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            wake_vec[i] = src_q[i].pend && src_q[i].en;
        end
    end
    assign idle_wake = |wake_vec;

    // source control words
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NSRC; i++) begin
            if (!aresetn) begin
                src_q[i] <= SRC_RESET;
            end else begin
                if (wr_src && wr_idx == 4'(i)) begin
                    src_q[i] <= src_new[7:0];
                end else if (accept && win_idx == 4'(i) &&
                        !(do_xfer && xfer_last)) begin
                    src_q[i].pend <= 1'b0;
                end
                if (src_req[i]) begin
                    src_q[i].pend <= 1'b1;
                end
            end
        end
    end

    // channel counts
    always_ff @(posedge aclk) begin
        for (int c = 0; c < NCHAN; c++) begin
            if (!aresetn) begin
                cnt_q[c] <= CNT_RESET;
            end else if (wr_chan && wr_ch == 3'(c)) begin
                cnt_q[c] <= cnt_new[7:0];
            end else if (do_xfer && win_ch == 3'(c)) begin
                cnt_q[c] <= cnt_dec;
            end
        end
    end

    // status word: hardware trap beats entry beats return beats software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psw_q <= PSW_RESET;
        end else if (hw_trap) begin
            psw_q[PSW_LVL_LSB +: 4] <= LVL_MAX;
        end else if (do_isr) begin
            psw_q[PSW_LVL_LSB +: 4] <= win_lvl;
        end else if (psw_pop) begin
            psw_q <= psw_pop_data & PSW_WMASK;
        end else if (wr_psw) begin
            psw_q <= psw_new[15:0] & PSW_WMASK;
        end
    end

    // service strobes, one cycle each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isr <= '0;
            xfer <= '0;
            push <= '0;
        end else begin
            isr <= '{do_isr, win_idx, win_lvl};
            xfer <= '{do_xfer, win_idx, win_ch, xfer_last};
            // old word is pushed on entry and on traps
            push <= '{do_isr || trap_any, psw_q};
        end
    end

    // bus slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wr_src || wr_chan || wr_psw) ? RESP_OKAY :
                    RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    wire rd_src = src_hit(araddr);
    wire rd_chan = chan_hit(araddr);
    wire rd_psw = araddr == PSW_ADDR;
    wire [31:0] rd_val = rd_psw ? {16'h0000, psw_q} :
        rd_src ? {24'h0000_00, src_q[araddr[5:2]]} :
        rd_chan ? {24'h0000_00, cnt_q[araddr[4:2]]} : 32'h0000_0000;
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
            araddr_q <= '0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= (rd_src || rd_chan || rd_psw) ? RESP_OKAY : RESP_SLVERR;
            araddr_q <= araddr;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks
    logic [NSRC-1:0] pend_vec;
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            pend_vec[i] = src_q[i].pend;
        end
    end

    // second search kept apart from the arbiter loop so a slip shows
    logic beaten;
    always_comb begin
        beaten = 1'b0;
        for (int j = 0; j < NSRC; j++) begin
            if (elig[j] && ({src_q[j].lvl, src_q[j].grp} > win_key ||
                    ({src_q[j].lvl, src_q[j].grp} == win_key &&
                    4'(j) < win_idx))) begin
                beaten = 1'b1;
            end
        end
    end

    // all checks share the one clock and the synchronous reset
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_entry;
        do_isr ##1 isr.valid;
    endsequence
    sequence s_level_loaded;
        cpu_lvl == isr.lvl && push.valid && push.data[15:12] < isr.lvl;
    endsequence

    a_entry_push_load: assert property (s_entry |-> s_level_loaded)
        else $error("entry did not push and load level");
    a_accept_above: assert property (
        isr.valid |-> $past(cpu_lvl) < isr.lvl && isr.lvl != 4'h0)
        else $error("accepted request not above cpu level");
    a_req_sets_pend: assert property (
        src_req != '0 |=> (pend_vec & $past(src_req)) == $past(src_req))
        else $error("request did not set pending flag");
    a_xfer_last_keeps: assert property (
        xfer.valid && xfer.last && !$past(wr_src) |-> pend_vec[xfer.src])
        else $error("pending cleared on final transfer");
    a_xfer_keeps_level: assert property (
        xfer.valid && !$past(wr_psw) && !$past(psw_pop) && !$past(hw_trap)
        |-> cpu_lvl == $past(cpu_lvl))
        else $error("transfer changed cpu level");
    a_hw_trap_level: assert property (
        hw_trap |=> cpu_lvl == LVL_MAX ##1 !isr.valid && !xfer.valid)
        else $error("hardware trap did not raise level");
    a_sw_trap_level: assert property (
        sw_trap && !hw_trap && !psw_pop && !wr_psw |=> $stable(cpu_lvl))
        else $error("software trap changed level");
    a_enable_gates: assert property (
        !global_irq_enable |=> !isr.valid && !xfer.valid)
        else $error("service while globally disabled");
    a_low_lvl_cpu: assert property (
        do_isr || do_xfer |-> ((win_lvl[3:1] == XFER_LVL) == do_xfer) ||
        cnt_q[win_ch] == 8'h00)
        else $error("wrong service type chosen");
    a_xfer_channel: assert property (
        do_xfer |=> xfer.chan == {$past(win_lvl[0]), $past(win_key[1:0])})
        else $error("wrong channel selected");
    a_winner_best: assert property (
        win_found |-> !beaten)
        else $error("arbitration winner is not the best request");
    a_trap_push: assert property (
        trap_any |=> push.valid && !isr.valid && !xfer.valid)
        else $error("trap did not push or did not block service");
    a_sw_write_pend: assert property (
        wr_src && !src_req[wr_idx] |=>
        pend_vec[$past(wr_idx)] == $past(src_new[SRC_PEND_BIT]))
        else $error("software write of pending flag lost");
    a_one_service: assert property (
        isr.valid || xfer.valid |->
        $past(cycle_end) && !(isr.valid && xfer.valid))
        else $error("service outside cycle end or twice");
    a_final_count: assert property (
        xfer.valid && xfer.last && !$past(wr_chan) |->
        cnt_q[xfer.chan] == 8'h00)
        else $error("last transfer flagged with count left");
    a_entry_clears: assert property (
        isr.valid && $past(src_req) == '0 && !$past(wr_src) |->
        !pend_vec[isr.src])
        else $error("entry did not clear pending flag");
    a_eligible_served: assert property (
        cycle_end && win_found && global_irq_enable && !trap_any &&
        win_lvl > cpu_lvl |=> isr.valid || xfer.valid)
        else $error("eligible request above cpu level not served");
endmodule : pia_arbiter

/* File: pia_arbiter_test.sv */
// Purpose: self-checking bench of the interrupt and transfer arbiter
// Assumes: axi4-lite master per the hand-over contract, 50 MHz clock
// Notes: outputs are sampled 1 ns after the edge that registers them
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %0t got %h want %h", $time, a, e); end end
module pia_arbiter_test;
    import pia_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0, idle_wake;
    logic [AW-1:0] awaddr = '0, araddr = '0;
    logic [3:0] wstrb = 4'hf;
    logic [2:0] awprot = 3'b000, arprot = 3'b000;
    logic [31:0] wdata = '0, rdata, rd;
    logic [1:0] bresp, rresp, rr;
    logic [NSRC-1:0] src_req;
    logic cycle_end, hw_trap, sw_trap, psw_pop;
    logic [15:0] psw_pop_data;
    pia_isr_t isr;
    pia_xfer_t xfer;
    pia_push_t push;
    int miscompares = 0, compares = 0, cyc = 0;

    always #10 aclk = ~aclk;

    pia_partner cpu (.aclk(aclk), .src_req(src_req), .cycle_end(cycle_end),
        .hw_trap(hw_trap), .sw_trap(sw_trap), .psw_pop(psw_pop),
        .psw_pop_data(psw_pop_data));

    pia_arbiter dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .src_req(src_req),
        .cycle_end(cycle_end), .hw_trap(hw_trap), .sw_trap(sw_trap),
        .psw_pop(psw_pop), .psw_pop_data(psw_pop_data), .isr(isr),
        .xfer(xfer), .push(push), .idle_wake(idle_wake));

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdw(input logic [15:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rdw

    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            results();
        end
    end

    task automatic t_reset;
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_0000)
        rdw(16'h0100);
        `CHK(rr, RESP_SLVERR)
        wr(16'h0100, 32'h0000_0000);
        `CHK(rr, RESP_SLVERR)
        @(posedge aclk);
        wstrb <= 4'h2;
        wr(PSW_ADDR, 32'h0000_ffff);
        `CHK(rr, RESP_OKAY)
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_f800)
        @(posedge aclk);
        wstrb <= 4'hf;
        wr(PSW_ADDR, 32'h0000_0000);
        $display("reset and map done");
    endtask : t_reset

    // three sources, two share level 5 with distinct groups
    task automatic t_prio;
        wr(16'h0008, 32'h0000_0055);
        wr(16'h000c, 32'h0000_0056);
        wr(16'h0010, 32'h0000_004f);
        wr(PSW_ADDR, 32'h0000_0800);
        cpu.request(16'h001c);
        cpu.strobe(0, 2);
        #1;
        `CHK(isr, pia_isr_t'({1'b1, 4'd3, 4'd5}))
        `CHK(push, pia_push_t'({1'b1, 16'h0800}))
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_5800)
        rdw(16'h000c);
        `CHK(rd, 32'h0000_0056)
        cpu.strobe(0, 0);
        #1;
        `CHK(isr.valid, 1'b0)
        wr(PSW_ADDR, 32'h0000_4800);
        cpu.strobe(0, 0);
        #1;
        `CHK(isr, pia_isr_t'({1'b1, 4'd2, 4'd5}))
        $display("priority and nesting done");
    endtask : t_prio

    // level 15 group 2 goes to channel 6 with one transfer left
    task automatic t_xfer;
        wr(PSW_ADDR, 32'h0000_0800);
        wr(16'h0014, 32'h0000_007e);
        wr(CHAN_BASE + 16'h0018, 32'h0000_0001);
        cpu.request(16'h0020);
        cpu.strobe(0, 0);
        #1;
        `CHK(xfer, pia_xfer_t'({1'b1, 4'd5, 3'd6, 1'b1}))
        `CHK(isr.valid, 1'b0)
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_0800)
        rdw(16'h0014);
        `CHK(rd, 32'h0000_00fe)
        cpu.strobe(0, 0);
        #1;
        `CHK(isr, pia_isr_t'({1'b1, 4'd5, 4'd15}))
        `CHK(xfer.valid, 1'b0)
        wr(16'h0010, 32'h0000_000f);
        cpu.request(16'h0010);
        #1;
        `CHK(idle_wake, 1'b0)
        wr(16'h0018, 32'h0000_0040);
        cpu.request(16'h0040);
        #1;
        `CHK(idle_wake, 1'b1)
        $display("event transfer done");
    endtask : t_xfer

    // global enable off, then traps which ignore it
    task automatic t_gate;
        wr(PSW_ADDR, 32'h0000_3000);
        cpu.request(16'h0008);
        cpu.strobe(0, 0);
        #1;
        `CHK(isr.valid, 1'b0)
        cpu.strobe(2, 1);
        #1;
        `CHK(push, pia_push_t'({1'b1, 16'h3000}))
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_3000)
        cpu.strobe(1, 0);
        #1;
        `CHK(push.valid, 1'b1)
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_f000)
        cpu.ret(16'h48ff);
        rdw(PSW_ADDR);
        `CHK(rd, 32'h0000_487f)
        $display("gating and traps done");
    endtask : t_gate

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_prio();
        t_xfer();
        t_gate();
        results();
    end
endmodule : pia_arbiter_test

/* File: pia_partner.sv */
// Purpose: model of the request sources and the cpu core around the arbiter
// Assumes: every strobe is one aclk cycle wide
// Notes: cpu may wait idle cycles before an instruction ends (slow answer)
`timescale 1ns/1ps
module pia_partner
    import pia_pkg::*;
(
    // clock
    input wire logic aclk,
    // strobes towards the arbiter
    output logic [NSRC-1:0] src_req,
    output logic cycle_end,
    output logic hw_trap,
    output logic sw_trap,
    output logic psw_pop,
    output logic [15:0] psw_pop_data
);
    initial begin
        src_req = '0;
        cycle_end = 1'b0;
        hw_trap = 1'b0;
        sw_trap = 1'b0;
        psw_pop = 1'b0;
        psw_pop_data = 16'h0000;
    end

    // one-cycle request pulse on the given sources
    task automatic request(input logic [NSRC-1:0] m);
        @(posedge aclk);
        src_req <= m;
        @(posedge aclk);
        src_req <= '0;
    endtask : request

    // kind 0 instruction end, 1 hardware trap, 2 software trap
    task automatic strobe(input int kind, input int idle);
        repeat (idle) @(posedge aclk);
        @(posedge aclk);
        cycle_end <= (kind == 0);
        hw_trap <= (kind == 1);
        sw_trap <= (kind == 2);
        @(posedge aclk);
        {cycle_end, hw_trap, sw_trap} <= 3'b000;
    endtask : strobe

    // return from a service routine, restoring the given saved word
    task automatic ret(input logic [15:0] d);
        @(posedge aclk);
        psw_pop <= 1'b1;
        psw_pop_data <= d;
        @(posedge aclk);
        psw_pop <= 1'b0;
    endtask : ret
endmodule : pia_partner

/* File: pia_pkg.sv */
// Purpose: shared constants and types of the priority interrupt arbiter
// Assumes: 32-bit AXI4-Lite register bus, 16-bit byte addresses
// Notes: source and channel register offsets sit at the low end of the map
package pia_pkg;
    localparam int NSRC = 16;
    localparam int NCHAN = 8;
    localparam int AW = 16;
    // register map (byte addresses)
    localparam logic [15:0] PSW_ADDR = 16'hff10;
    localparam logic [15:0] SRC_BASE = 16'h0000;
    localparam logic [15:0] CHAN_BASE = 16'h0040;
    // status word layout
    localparam int PSW_LVL_LSB = 12;
    localparam int PSW_GLOBAL_EN_BIT = 11;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [15:0] PSW_WMASK = 16'hf87f;
    // source control word layout, low byte
    localparam int SRC_PEND_BIT = 7;
    localparam int SRC_EN_BIT = 6;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_CONT = 8'hff;
    localparam logic [3:0] LVL_MAX = 4'hf;
    localparam logic [2:0] XFER_LVL = 3'b111;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic pend;
        logic en;
        logic [3:0] lvl;
        logic [1:0] grp;
    } pia_src_t;

    typedef struct packed {
        logic valid;
        logic [3:0] src;
        logic [3:0] lvl;
    } pia_isr_t;

    typedef struct packed {
        logic valid;
        logic [3:0] src;
        logic [2:0] chan;
        logic last;
    } pia_xfer_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } pia_push_t;
endpackage : pia_pkg
